// ==== common/tpslc_pkg.sv ====
// shared constants and types of the transmit pulse shaper and line control
package tpslc_pkg;
   // register port
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_CFG_A  = 8'h02;
   localparam logic [ADDR_W-1:0] ADDR_CFG_B  = 8'h03;
   localparam logic [ADDR_W-1:0] ADDR_SCALE  = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h05;
   localparam logic [ADDR_W-1:0] ADDR_MODE   = 8'h06;
   localparam logic [ADDR_W-1:0] ADDR_SWRST  = 8'h07;
   localparam logic [ADDR_W-1:0] ADDR_TERM   = 8'h1a;
   // field positions
   localparam int PWR_OFF_BIT  = 0;
   localparam int TMPL_LSB     = 0;
   localparam int TMPL_W       = 4;
   localparam int HIZ_BIT      = 4;
   localparam int TERM_SEL_LSB = 0;
   localparam int TERM_SEL_W   = 2;
   localparam int TERM_EXT_BIT = 2;
   localparam int RLB_BIT      = 0;
   localparam int IPAT_BIT     = 1;
   localparam int SWRST_BIT    = 0;
   localparam logic [1:0] TMPL_DS1_HI = 2'h2;
   // values after reset; tristate set so the line stays quiet until software opens it
   localparam logic [DATA_W-1:0] CFG_A_RST = 8'h00;
   localparam logic [DATA_W-1:0] CFG_B_RST = 8'h10;
   localparam logic [DATA_W-1:0] TERM_RST  = 8'h00;
   localparam logic [DATA_W-1:0] MODE_RST  = 8'h00;
   // shaping
   localparam int CODE_W    = 7;
   localparam int SMP_W     = 4;
   localparam int UI_SPAN   = 4;
   localparam int UI_W      = 2;
   localparam int NUM_TMPL  = 4;
   localparam int TSEL_W    = 2;
   localparam int SCALE_W   = 6;
   localparam int SUM_W     = 9;
   localparam int LVL_W     = 14;
   localparam int GAIN_W    = 12;
   localparam int GAIN_FRAC = 11;
   localparam int PROD_W    = 28;
   localparam logic [SMP_W-1:0] SMP_LAST = 4'hf;
   typedef logic [SCALE_W-1:0] tpslc_scale_t;
   typedef logic [GAIN_W-1:0]  tpslc_gain_t;
   localparam tpslc_scale_t SCALE_DEF [NUM_TMPL] = '{6'h36, 6'h11, 6'h08, 6'h04};
   localparam tpslc_scale_t SCALE_RST = SCALE_DEF[0];
   // gain over 2^11: one scale step is 2%, 6.25%, 12.5% and 25% of the pulse
   localparam tpslc_gain_t  TMPL_GAIN [NUM_TMPL] = '{12'h029, 12'h080, 12'h100, 12'h200};
   // timing
   localparam int SYS_CLK_MHZ      = 250;
   localparam int SAMPLE_PERIOD_PS = 40500;
   localparam int SAMPLE_DIV_CYC   = SAMPLE_PERIOD_PS * SYS_CLK_MHZ / 1000000;
   localparam int LOSS_TIMEOUT_NS  = 2000;
   localparam int LOSS_CYC         = (LOSS_TIMEOUT_NS * SYS_CLK_MHZ + 999) / 1000;
   localparam int CK_TX  = 0;
   localparam int CK_M   = 1;
   localparam int NUM_CK = 2;
   typedef enum logic {SE_IDLE = 1'b0, SE_RUN = 1'b1} tpslc_se_e;
endpackage

// ==== logic/tpslc_tmpl_rom.sv ====
// pulse template store: four build-out shapes, sixteen samples in each of four intervals
module tpslc_tmpl_rom (
   // shape and sample position
   input  wire logic [tpslc_pkg::TSEL_W-1:0]                  tmpl_sel,
   input  wire logic [tpslc_pkg::SMP_W-1:0]                   sample_idx,
   // one code per interval, interval one in the low bits
   output logic      [tpslc_pkg::UI_SPAN*tpslc_pkg::CODE_W-1:0] ui_code
);
   // bit 6 of a code is the sign against the mark, bits 5..0 the size
   localparam logic [6:0] ROM [256] = '{
      7'h17, 7'h27, 7'h27, 7'h26, 7'h25, 7'h25, 7'h25, 7'h24, 7'h23, 7'h4a, 7'h4a, 7'h49, 7'h47, 7'h45, 7'h44, 7'h43,
      7'h42, 7'h41, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00,
      7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00,
      7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00,
      7'h00, 7'h02, 7'h09, 7'h13, 7'h1d, 7'h25, 7'h2b, 7'h31, 7'h36, 7'h3a, 7'h39, 7'h30, 7'h28, 7'h20, 7'h1a, 7'h17,
      7'h14, 7'h12, 7'h10, 7'h0e, 7'h0c, 7'h0b, 7'h0a, 7'h09, 7'h08, 7'h07, 7'h06, 7'h05, 7'h04, 7'h04, 7'h03, 7'h03,
      7'h02, 7'h02, 7'h02, 7'h02, 7'h02, 7'h01, 7'h01, 7'h01, 7'h01, 7'h01, 7'h01, 7'h01, 7'h00, 7'h00, 7'h00, 7'h00,
      7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00,
      7'h00, 7'h00, 7'h00, 7'h01, 7'h04, 7'h08, 7'h0e, 7'h14, 7'h1b, 7'h22, 7'h2a, 7'h30, 7'h35, 7'h37, 7'h38, 7'h37,
      7'h35, 7'h33, 7'h30, 7'h2d, 7'h2a, 7'h27, 7'h24, 7'h21, 7'h1e, 7'h1c, 7'h1a, 7'h17, 7'h15, 7'h14, 7'h12, 7'h10,
      7'h0f, 7'h0d, 7'h0c, 7'h0b, 7'h0a, 7'h09, 7'h08, 7'h07, 7'h06, 7'h06, 7'h05, 7'h05, 7'h04, 7'h04, 7'h03, 7'h03,
      7'h03, 7'h02, 7'h02, 7'h02, 7'h02, 7'h01, 7'h01, 7'h01, 7'h01, 7'h01, 7'h01, 7'h01, 7'h01, 7'h00, 7'h00, 7'h00,
      7'h01, 7'h03, 7'h05, 7'h08, 7'h0c, 7'h11, 7'h16, 7'h1b, 7'h21, 7'h26, 7'h2a, 7'h2e, 7'h31, 7'h33, 7'h34, 7'h34,
      7'h35, 7'h35, 7'h34, 7'h33, 7'h32, 7'h30, 7'h2e, 7'h2d, 7'h2b, 7'h29, 7'h27, 7'h24, 7'h22, 7'h20, 7'h1e, 7'h1c,
      7'h1b, 7'h19, 7'h17, 7'h15, 7'h14, 7'h12, 7'h11, 7'h10, 7'h0e, 7'h0d, 7'h0c, 7'h0b, 7'h0a, 7'h09, 7'h08, 7'h08,
      7'h07, 7'h06, 7'h06, 7'h05, 7'h05, 7'h05, 7'h04, 7'h04, 7'h04, 7'h04, 7'h03, 7'h03, 7'h03, 7'h03, 7'h03, 7'h02
   };

   for (genvar ui = 0; ui < tpslc_pkg::UI_SPAN; ui++) begin : g_ui
      assign ui_code[ui*tpslc_pkg::CODE_W +: tpslc_pkg::CODE_W] = ROM[{tmpl_sel, tpslc_pkg::UI_W'(ui), sample_idx}];
   end
endmodule

// ==== logic/tpslc_top.sv ====
// transmit pulse shaper and line driver control of one channel
// What this block does
// R1 - 0 dB build-out: scale resets to 110110, one step moves amplitude 2%
// R2 - -7.5 dB build-out: scale default 010001, one step moves amplitude 6.25%
// R3 - -15.0 dB build-out: scale default 001000, one step moves amplitude 12.5%
// R4 - -22.5 dB build-out: scale default 000100, one step moves amplitude 25%
// R5 - 0 dB shape: 16 seven-bit samples over four intervals, as tabulated
// R6 - -7.5 dB shape starts 0000000, 0010100, 0000010, fourth interval zero
// R7 - -15.0 dB shape starts 0000000, 0110101, 0001111, 0000011, as tabulated
// R8 - -22.5 dB shape starts 0000001, 0110101, 0011011, 0000111, as tabulated
// R9 - termination top bit clear: internal match, low bits pick 75/120/100/110 ohm
// R10 - termination top bit set: internal match off, external parts used
// R11 - software never selects external termination in T1 or J1 mode
// R12 - template codes: E1, T1 length bands, J1, DS1 build-outs 1000 to 1011
// R13 - line tristated by global pin or the channel tristate bit
// R14 - while tristated by pin or bit the shaper keeps running
// R15 - master clock lost: line tristated
// R16 - transmit clock lost: line tristated unless remote loopback or mclk pattern
// R17 - after any reset the line stays tristated
// R18 - power-off bit stops the transmit path and tristates the line
// R19 - samples go out in order per interval; overlapping marks summed, then scaled
// R20 - clock lost after a timeout of missing edges, released when edges return
module tpslc_top #(
   parameter int unsigned SAMPLE_DIV = tpslc_pkg::SAMPLE_DIV_CYC,
   parameter int unsigned LOSS_CYC   = tpslc_pkg::LOSS_CYC
) (
   // clock and reset
   input  wire logic                             sys_clk,
   input  wire logic                             rst_n,
   // register port
   input  wire logic [tpslc_pkg::ADDR_W-1:0]     reg_addr,
   input  wire logic [tpslc_pkg::DATA_W-1:0]     reg_wdata,
   input  wire logic                             reg_wr,
   input  wire logic                             reg_rd,
   output logic      [tpslc_pkg::DATA_W-1:0]     reg_rdata,
   // clocks and marks from the transmit path, and the global tristate pin
   input  wire logic                             tx_clock_in,
   input  wire logic                             mclk_in,
   input  wire logic                             tx_mark_pos,
   input  wire logic                             tx_mark_neg,
   input  wire logic                             tx_tristate_pin,
   // line driver
   output logic      [tpslc_pkg::LVL_W-1:0]      tx_line_tip,
   output logic      [tpslc_pkg::LVL_W-1:0]      tx_line_ring,
   output logic                                  tx_line_tip_oe_n,
   output logic                                  tx_line_ring_oe_n,
   output logic                                  int_term_en,
   output logic      [tpslc_pkg::TERM_SEL_W-1:0] int_term_sel,
   output logic                                  tx_power_down
);
   localparam int DIV_W  = $clog2(SAMPLE_DIV + 1);
   localparam int LOSS_W = $clog2(LOSS_CYC + 1);

   logic                               rst_meta_q;
   logic                               rst_sync_n_q;
   logic [tpslc_pkg::DATA_W-1:0]       cfg_a_q;
   logic [tpslc_pkg::DATA_W-1:0]       cfg_b_q;
   logic [tpslc_pkg::DATA_W-1:0]       term_q;
   logic [tpslc_pkg::DATA_W-1:0]       mode_q;
   tpslc_pkg::tpslc_scale_t            scale_q;
   logic [tpslc_pkg::DATA_W-1:0]       rdata_q;
   logic                               soft_rst;
   logic                               power_off;
   logic [tpslc_pkg::TMPL_W-1:0]       tmpl;
   logic [tpslc_pkg::TSEL_W-1:0]       tsel;
   logic [tpslc_pkg::NUM_CK-1:0]       ck_in;
   logic [tpslc_pkg::NUM_CK-1:0]       ck_q;
   logic [tpslc_pkg::NUM_CK-1:0]       ck_edge;
   logic [tpslc_pkg::NUM_CK-1:0]       lost_q;
   logic                               ui_start;
   tpslc_pkg::tpslc_se_e               se_q;
   logic [DIV_W-1:0]                   div_q;
   logic [tpslc_pkg::SMP_W-1:0]        smp_q;
   logic                               stb_q;
   logic [tpslc_pkg::UI_SPAN-1:0]      hist_pos_q;
   logic [tpslc_pkg::UI_SPAN-1:0]      hist_neg_q;
   logic [tpslc_pkg::UI_SPAN*tpslc_pkg::CODE_W-1:0] codes;
   logic [tpslc_pkg::CODE_W-1:0]       code;
   logic signed [tpslc_pkg::SUM_W-1:0] val;
   logic signed [tpslc_pkg::SUM_W-1:0] sum;
   logic signed [tpslc_pkg::PROD_W-1:0] sum_w;
   logic signed [tpslc_pkg::PROD_W-1:0] scale_w;
   logic signed [tpslc_pkg::PROD_W-1:0] gain_w;
   logic signed [tpslc_pkg::PROD_W-1:0] prod;
   logic signed [tpslc_pkg::LVL_W-1:0] lvl;
   logic [tpslc_pkg::LVL_W-1:0]        tip_q;
   logic [tpslc_pkg::LVL_W-1:0]        ring_q;
   logic                               hiz;
   logic                               tip_oe_n_q;
   logic                               ring_oe_n_q;
   logic                               term_en_q;
   logic [tpslc_pkg::TERM_SEL_W-1:0]   term_sel_q;

   // reset release through two stages
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_q   <= 1'b0;
         rst_sync_n_q <= 1'b0;
      end else begin
         rst_meta_q   <= 1'b1;
         rst_sync_n_q <= rst_meta_q;
      end
   end

   assign soft_rst  = reg_wr && reg_addr == tpslc_pkg::ADDR_SWRST && reg_wdata[tpslc_pkg::SWRST_BIT];
   assign power_off = cfg_a_q[tpslc_pkg::PWR_OFF_BIT];
   assign tmpl      = cfg_b_q[tpslc_pkg::TMPL_LSB +: tpslc_pkg::TMPL_W];
   // only the build-out codes carry their own shape; the rest use the 0 dB one
   assign tsel      = (tmpl[3:2] == tpslc_pkg::TMPL_DS1_HI) ? tmpl[1:0] : '0;  // see R12

   // configuration registers; soft reset reloads them, which tristates the line
   always_ff @(posedge sys_clk or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
         cfg_a_q <= tpslc_pkg::CFG_A_RST;
         cfg_b_q <= tpslc_pkg::CFG_B_RST;  // see R17
         term_q  <= tpslc_pkg::TERM_RST;
         mode_q  <= tpslc_pkg::MODE_RST;
      end else if (soft_rst) begin
         cfg_a_q <= tpslc_pkg::CFG_A_RST;
         cfg_b_q <= tpslc_pkg::CFG_B_RST;  // see R17
         term_q  <= tpslc_pkg::TERM_RST;
         mode_q  <= tpslc_pkg::MODE_RST;
      end else if (reg_wr) begin
         if (reg_addr == tpslc_pkg::ADDR_CFG_A) begin
            cfg_a_q <= reg_wdata;
         end
         if (reg_addr == tpslc_pkg::ADDR_CFG_B) begin
            cfg_b_q <= reg_wdata;
         end
         if (reg_addr == tpslc_pkg::ADDR_TERM) begin
            term_q <= reg_wdata;
         end
         if (reg_addr == tpslc_pkg::ADDR_MODE) begin
            mode_q <= reg_wdata;
         end
      end
   end

   // choosing a build-out loads its default scale; a later scale write trims it
   always_ff @(posedge sys_clk or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
         scale_q <= tpslc_pkg::SCALE_RST;  // see R1
      end else if (soft_rst) begin
         scale_q <= tpslc_pkg::SCALE_RST;  // see R1
      end else if (reg_wr && reg_addr == tpslc_pkg::ADDR_CFG_B && reg_wdata[3:2] == tpslc_pkg::TMPL_DS1_HI) begin
         scale_q <= tpslc_pkg::SCALE_DEF[reg_wdata[1:0]];  // see R2, see R3, see R4
      end else if (reg_wr && reg_addr == tpslc_pkg::ADDR_SCALE) begin
         scale_q <= reg_wdata[tpslc_pkg::SCALE_W-1:0];
      end
   end

   // read data in the cycle after the strobe; unmapped addresses read zero
   always_ff @(posedge sys_clk or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
         rdata_q <= '0;
      end else if (reg_rd) begin
         unique case (reg_addr)
            tpslc_pkg::ADDR_CFG_A:  rdata_q <= cfg_a_q;
            tpslc_pkg::ADDR_CFG_B:  rdata_q <= cfg_b_q;
            tpslc_pkg::ADDR_TERM:   rdata_q <= term_q;
            tpslc_pkg::ADDR_MODE:   rdata_q <= mode_q;
            tpslc_pkg::ADDR_SCALE:  rdata_q <= {2'h0, scale_q};
            tpslc_pkg::ADDR_STATUS: rdata_q <= {4'h0, term_q[tpslc_pkg::TERM_EXT_BIT], tip_oe_n_q, lost_q};
            default:                rdata_q <= '0;
         endcase
      end else begin
         rdata_q <= '0;
      end
   end
   assign reg_rdata = rdata_q;

   // clock watchdogs timed by sys_clk, which never stops
   assign ck_in = {mclk_in, tx_clock_in};
   for (genvar c = 0; c < tpslc_pkg::NUM_CK; c++) begin : g_watch
      logic [LOSS_W-1:0] idle_q;
      assign ck_edge[c] = ck_in[c] & ~ck_q[c];
      always_ff @(posedge sys_clk or negedge rst_sync_n_q) begin
         if (!rst_sync_n_q) begin
            ck_q[c]   <= 1'b0;
            idle_q    <= '0;
            lost_q[c] <= 1'b0;
         end else begin
            ck_q[c] <= ck_in[c];
            if (ck_edge[c]) begin
               idle_q    <= '0;
               lost_q[c] <= 1'b0;  // see R20
            end else if (idle_q == LOSS_W'(LOSS_CYC - 1)) begin
               lost_q[c] <= 1'b1;  // see R20
            end else begin
               idle_q <= idle_q + 1'b1;
            end
         end
      end
   end

   // a new interval starts on each rising transmit clock edge while powered
   assign ui_start = ck_edge[tpslc_pkg::CK_TX] && !power_off;  // see R18

   // mark history: bit 0 is the current interval, bit 3 three intervals back
   always_ff @(posedge sys_clk or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
         hist_pos_q <= '0;
         hist_neg_q <= '0;
      end else if (power_off) begin
         hist_pos_q <= '0;
         hist_neg_q <= '0;
      end else if (ui_start) begin
         hist_pos_q <= {hist_pos_q[tpslc_pkg::UI_SPAN-2:0], tx_mark_pos};
         hist_neg_q <= {hist_neg_q[tpslc_pkg::UI_SPAN-2:0], tx_mark_neg & ~tx_mark_pos};
      end
   end

   // sample pacing: one strobe per divider period, sixteen per interval;
   // tristate does not stop it, so the driver is ready the moment it opens
   always_ff @(posedge sys_clk or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
         se_q  <= tpslc_pkg::SE_IDLE;
         div_q <= '0;
         smp_q <= '0;
         stb_q <= 1'b0;
      end else if (ui_start) begin
         se_q  <= tpslc_pkg::SE_RUN;  // see R14
         div_q <= '0;
         smp_q <= '0;  // see R19
         stb_q <= 1'b1;
      end else begin
         stb_q <= 1'b0;
         unique case (se_q)
            tpslc_pkg::SE_IDLE: div_q <= '0;
            tpslc_pkg::SE_RUN: begin
               if (power_off) begin
                  se_q <= tpslc_pkg::SE_IDLE;
               end else if (div_q == DIV_W'(SAMPLE_DIV - 1)) begin
                  div_q <= '0;
                  if (smp_q == tpslc_pkg::SMP_LAST) begin
                     se_q <= tpslc_pkg::SE_IDLE;
                  end else begin
                     smp_q <= smp_q + 1'b1;  // see R19
                     stb_q <= 1'b1;
                  end
               end else begin
                  div_q <= div_q + 1'b1;
               end
            end
         endcase
      end
   end

   tpslc_tmpl_rom u_rom (
      .tmpl_sel   (tsel),
      .sample_idx (smp_q),
      .ui_code    (codes)
   );

   // overlapping marks summed in full before the scale, so tails never clip early
   always_comb begin
      sum  = '0;
      code = '0;
      val  = '0;
      for (int k = 0; k < tpslc_pkg::UI_SPAN; k++) begin
         code = codes[k*tpslc_pkg::CODE_W +: tpslc_pkg::CODE_W];
         val  = code[6] ? -$signed({3'h0, code[5:0]}) : $signed({3'h0, code[5:0]});
         if (hist_pos_q[k]) begin
            sum = sum + val;  // see R19
         end else if (hist_neg_q[k]) begin
            sum = sum - val;  // see R19
         end
      end
   end

   assign sum_w   = tpslc_pkg::PROD_W'(sum);
   assign scale_w = {22'h0, scale_q};
   assign gain_w  = {16'h0, tpslc_pkg::TMPL_GAIN[tsel]};
   assign prod    = sum_w * scale_w * gain_w;  // see R1, see R2, see R3, see R4
   assign lvl     = prod[tpslc_pkg::GAIN_FRAC +: tpslc_pkg::LVL_W];

   // tip carries the positive half of the drive, ring the negative half
   always_ff @(posedge sys_clk or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
         tip_q  <= '0;
         ring_q <= '0;
      end else if (power_off) begin
         tip_q  <= '0;  // see R18
         ring_q <= '0;
      end else if (stb_q) begin
         tip_q  <= (lvl > 0) ? lvl : '0;
         ring_q <= (lvl < 0) ? -lvl : '0;
      end
   end

   assign hiz = tx_tristate_pin | cfg_b_q[tpslc_pkg::HIZ_BIT]        // see R13
              | power_off                                          // see R18
              | lost_q[tpslc_pkg::CK_M]                            // see R15
              | (lost_q[tpslc_pkg::CK_TX] & ~mode_q[tpslc_pkg::RLB_BIT] & ~mode_q[tpslc_pkg::IPAT_BIT]);  // see R16

   always_ff @(posedge sys_clk or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
         tip_oe_n_q  <= 1'b1;  // see R17
         ring_oe_n_q <= 1'b1;
      end else begin
         tip_oe_n_q  <= hiz;
         ring_oe_n_q <= hiz;
      end
   end

   // termination follows its register one cycle later
   always_ff @(posedge sys_clk or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
         term_en_q  <= 1'b1;
         term_sel_q <= '0;
      end else begin
         term_en_q  <= ~term_q[tpslc_pkg::TERM_EXT_BIT];  // see R10
         term_sel_q <= term_q[tpslc_pkg::TERM_SEL_LSB +: tpslc_pkg::TERM_SEL_W];  // see R9
      end
   end

   assign tx_line_tip       = tip_q;
   assign tx_line_ring      = ring_q;
   assign tx_line_tip_oe_n  = tip_oe_n_q;
   assign tx_line_ring_oe_n = ring_oe_n_q;
   assign int_term_en       = term_en_q;
   assign int_term_sel      = term_sel_q;
   assign tx_power_down     = cfg_a_q[tpslc_pkg::PWR_OFF_BIT];

   // checks
   logic [tpslc_pkg::SMP_W-1:0] last_smp_q;
   always_ff @(posedge sys_clk or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
         last_smp_q <= '0;
      end else if (stb_q) begin
         last_smp_q <= smp_q;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_sync_n_q);

   scale_reload_a:  // see R1 see R2 see R3 see R4
   assert property (reg_wr && reg_addr == tpslc_pkg::ADDR_CFG_B && reg_wdata[3:2] == 2'h2 && !soft_rst
                    |=> scale_q == tpslc_pkg::SCALE_DEF[$past(reg_wdata[1:0])])
      else $error("scale not loaded with build-out default");
   tmpl_zero_a:  // see R5
   assert property (tsel == 2'h0 && smp_q == 4'h0 |-> codes == {7'h00, 7'h00, 7'h42, 7'h17})
      else $error("0 dB shape start wrong");
   tmpl_m75_a:  // see R6
   assert property (tsel == 2'h1 && smp_q == 4'h0 |-> codes == {7'h00, 7'h02, 7'h14, 7'h00})
      else $error("-7.5 dB shape start wrong");
   tmpl_m15_a:  // see R7
   assert property (tsel == 2'h2 && smp_q == 4'h0 |-> codes == {7'h03, 7'h0f, 7'h35, 7'h00})
      else $error("-15 dB shape start wrong");
   tmpl_m225_a:  // see R8
   assert property (tsel == 2'h3 && smp_q == 4'h0 |-> codes == {7'h07, 7'h1b, 7'h35, 7'h01})
      else $error("-22.5 dB shape start wrong");
   term_follow_a:  // see R9 see R10
   assert property (reg_wr && reg_addr == tpslc_pkg::ADDR_TERM && !soft_rst
                    |-> ##2 int_term_en == !$past(reg_wdata[2], 2) && int_term_sel == $past(reg_wdata[1:0], 2))
      else $error("termination select not followed");
   pin_hiz_a:  // see R13 see R15 see R18
   assert property (tx_tristate_pin || lost_q[tpslc_pkg::CK_M] || power_off |=> tx_line_tip_oe_n && tx_line_ring_oe_n)
      else $error("line driven while it must float");
   tclk_hiz_a:  // see R16
   assert property (lost_q[tpslc_pkg::CK_TX] && mode_q[1:0] == 2'h0 |=> tx_line_tip_oe_n)
      else $error("line driven after transmit clock loss");
   runs_hiz_a:  // see R14
   assert property (disable iff (!rst_sync_n_q || power_off)
                    ui_start |=> stb_q && smp_q == 4'h0 ##(SAMPLE_DIV) stb_q && smp_q == 4'h1)
      else $error("shaper stalled");
   smp_order_a:  // see R19
   assert property (stb_q && smp_q != 4'h0 |-> smp_q == last_smp_q + 4'h1)
      else $error("sample out of order");
   soft_hiz_a:  // see R17
   assert property (soft_rst |=> ##1 tx_line_tip_oe_n [*2])
      else $error("line driven right after soft reset");
   loss_det_a:  // see R20
   assert property (!ck_edge[0] [*8] ##1 g_watch[0].idle_q == LOSS_W'(LOSS_CYC - 1) && !ck_edge[0] |=> lost_q[0])
      else $error("transmit clock loss not declared");
   loss_rel_a:  // see R20
   assert property (lost_q[1] && ck_edge[1] |=> !lost_q[1])
      else $error("master clock loss not released");

   ds1_pulse_c: cover property (ui_start && tsel == 2'h3 && hist_pos_q[0]);
   tclk_loss_c: cover property (lost_q[0] ##1 !lost_q[0]);
   mclk_loss_c: cover property (lost_q[1]);
   line_on_c:   cover property (!tx_line_tip_oe_n && stb_q);
endmodule

// ==== bench/tpslc_line_model.sv ====
// cable model: differential level on the line and whether it is released
module tpslc_line_model #(
   parameter int W = tpslc_pkg::LVL_W
) (
   // driver side
   input  wire logic [W-1:0] tip,
   input  wire logic [W-1:0] ring,
   input  wire logic         oe_n,
   // observed line
   output logic              hiz,
   output logic [W:0]        lvl
);
   logic [W:0] diff;
   assign diff = {1'h0, tip} - {1'h0, ring};
   assign hiz = oe_n;
   // released line floats: show the inverse so a stale level is never trusted
   assign lvl = oe_n ? ~diff : diff;
endmodule

// ==== bench/tb_tpslc_top.sv ====
// self-checking bench of the pulse shaper and line control
module tb_tpslc_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, want = 0, wneg = 0, tclk_run = 1, mclk_run = 1;
   logic        tx_clock_in = 0, mclk_in = 0, tx_mark_pos = 0, tx_mark_neg = 0, tx_tristate_pin = 0;
   logic [7:0]  reg_addr = 0, reg_wdata = 0, reg_rdata;
   logic [13:0] tip, ring;
   logic [14:0] lvl;
   logic        oe_n, ring_oe_n, term_en, pwr_dn, hiz;
   logic [1:0]  term_sel;
   logic [5:0]  cnt = 0;
   logic [7:0]  dflt [4] = '{8'h36, 8'h11, 8'h08, 8'h04};
   logic [7:0]  tp [3] = '{8'h0b, 8'h09, 8'h08};
   logic [7:0]  sc [3] = '{8'h04, 8'h11, 8'h37};
   logic [13:0] ex [3] = '{14'h0001, 14'h0002, 14'h0019};
   int          n_mismatch = 0, comparisons = 0;
   always #2 sys_clk = ~sys_clk;
   tpslc_top #(.SAMPLE_DIV(2), .LOSS_CYC(60)) dut_u (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .tx_clock_in, .mclk_in, .tx_mark_pos, .tx_mark_neg, .tx_tristate_pin, .tx_line_tip(tip),
      .tx_line_ring(ring), .tx_line_tip_oe_n(oe_n), .tx_line_ring_oe_n(ring_oe_n), .int_term_en(term_en),
      .int_term_sel(term_sel), .tx_power_down(pwr_dn));
   tpslc_line_model line_u (.tip, .ring, .oe_n, .hiz, .lvl);
   // one interval per 40 cycles, so all 16 samples of 2 cycles go out
   always @(posedge sys_clk) begin
      cnt <= (cnt == 6'h27) ? 6'h00 : cnt + 6'h01;
      tx_clock_in <= tclk_run && cnt < 6'h14;
      tx_mark_pos <= want;
      tx_mark_neg <= wneg;
      mclk_in <= mclk_run && !mclk_in;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1;
      @(posedge sys_clk);
      reg_wr <= 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1;
      @(posedge sys_clk);
      reg_rd <= 0;
      #1;
      chk(reg_rdata, exp);
   endtask
   // bounded wait on tip or on the line state; running out shows as a mismatch
   // sel 0 line state, 1 tip, 2 line level seen by the cable model
   task automatic wait_on(input int sel, input logic [13:0] exp);
      logic [13:0] got;
      got = '0;
      for (int i = 0; i < 300; i++) begin
         @(posedge sys_clk);
         #1;
         got = (sel == 2) ? lvl[13:0] : (sel == 1) ? tip : {13'h0, hiz};
         if (got === exp) break;
      end
      chk(got, exp);
      if (got !== exp) close_out();
   endtask
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge sys_clk);
      rst_n <= 1;
      repeat (3) @(posedge sys_clk);
      chk(hiz, 1'h1);
      rd(8'h03, 8'h10);
      rd(8'h04, 8'h36);
      rd(8'h01, 8'h00);
      for (int i = 0; i < 4; i++) begin
         wr(8'h03, 8'h08 + 8'(i));
         rd(8'h04, dflt[i]);
      end
      $display("scale defaults done");
      for (int i = 0; i < 3; i++) begin
         wr(8'h03, tp[i]);
         wr(8'h04, sc[i]);
         want <= 1;
         wait_on(1, ex[i]);
         chk({hiz, ring_oe_n}, 2'h0);
         want <= 0;
         repeat (250) @(posedge sys_clk);
      end
      @(posedge sys_clk);
      tx_tristate_pin <= 1;
      want <= 1;
      wait_on(1, 14'h0019);
      wait_on(0, 14'h0001);
      chk(ring_oe_n, 1'h1);
      want <= 0;
      @(posedge sys_clk);
      tx_tristate_pin <= 0;
      repeat (250) @(posedge sys_clk);
      // a lone negative mark drives ring: -23 * 55 * 41 >> 11 is -26 on the line
      wneg <= 1;
      wait_on(2, 14'h3fe6);
      wneg <= 0;
      $display("shaping done");
      wr(8'h1a, 8'h01);
      wait_on(0, 14'h0000);
      chk({term_en, term_sel}, 3'h5);
      wr(8'h03, 8'h01);
      wr(8'h1a, 8'h04);
      repeat (2) @(posedge sys_clk);
      chk(term_en, 1'h0);
      wr(8'h1a, 8'h01);
      wr(8'h02, 8'h01);
      wait_on(0, 14'h0001);
      chk(pwr_dn, 1'h1);
      wr(8'h02, 8'h00);
      wait_on(0, 14'h0000);
      tclk_run <= 0;
      wait_on(0, 14'h0001);
      rd(8'h05, 8'h05);
      wr(8'h06, 8'h01);
      wait_on(0, 14'h0000);
      wr(8'h06, 8'h02);
      wait_on(0, 14'h0000);
      mclk_run <= 0;
      wait_on(0, 14'h0001);
      mclk_run <= 1;
      tclk_run <= 1;
      wr(8'h06, 8'h00);
      wait_on(0, 14'h0000);
      $display("line control done");
      wr(8'h07, 8'h01);
      wait_on(0, 14'h0001);
      rd(8'h03, 8'h10);
      $display("soft reset done");
      close_out();
   end
endmodule
